// ---- include/scg_pkg.sv ----
package scg_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [11:0] SLEEP_CTRL_OFS   = 12'h000;
	localparam logic [11:0] PERIPH_GATE_OFS  = 12'h004;
	localparam logic [11:0] MCU_CTRL_OFS     = 12'h008;
	localparam logic [11:0] STATUS_OFS       = 12'h00C;

	localparam int SE_BIT                    = 0;
	localparam int MODE_LSB                  = 1;
	localparam int MODE_W                    = 3;
	localparam int TPD_BIT                   = 0;
	localparam int PRR_W                     = 4;
	localparam int ST_STATE_LSB              = 0;
	localparam int ST_CLK_LSB                = 4;

	localparam logic [2:0] SLEEP_CTRL_RST    = 3'h0;
	localparam logic [3:0] PRR_RST           = 4'h0;

	// ************************************************************
	// Sleep mode codes
	// ************************************************************
	localparam logic [2:0] CODE_IDLE         = 3'h0;
	localparam logic [2:0] CODE_ADCNR        = 3'h1;
	localparam logic [2:0] CODE_PDOWN        = 3'h2;
	localparam logic [2:0] CODE_PSAVE        = 3'h3;
	localparam logic [2:0] CODE_STBY         = 3'h6;

	// ************************************************************
	// Timing, in clock cycles, and fuse decoding
	// ************************************************************
	localparam logic [10:0] HALT_CYC         = 11'h004;
	localparam logic [10:0] STBY_WAKE_CYC    = 11'h006;
	localparam logic [10:0] RESTART_XTAL_CYC = 11'h400;
	localparam logic [10:0] RESTART_RC_CYC   = 11'h040;
	localparam int XTAL_FUSE_BIT             = 3;
	localparam logic [2:0] BOD_OFF_CODE      = 3'h7;

	typedef enum logic [4:0] {
		MODE_IDLE  = 5'b00001,
		MODE_ADCNR = 5'b00010,
		MODE_PDOWN = 5'b00100,
		MODE_PSAVE = 5'b01000,
		MODE_STBY  = 5'b10000
	} scg_mode_t;

	typedef enum logic [3:0] {
		ST_ACTIVE  = 4'b0001,
		ST_SLEEP   = 4'b0010,
		ST_RESTART = 4'b0100,
		ST_HALT    = 4'b1000
	} scg_state_t;

	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic asy;
		logic main_osc;
		logic timer_osc;
	} scg_clk_en_t;

	// Wake events from logic on the same clock
	typedef struct packed {
		logic adc_done;
		logic ext_reset;
		logic wdt_reset;
		logic bod_reset;
		logic t2_ovf;
		logic t2_cmp;
		logic spm_ready;
		logic other_io;
	} scg_wake_t;

	// Wake events straight from pins
	typedef struct packed {
		logic ext_irq_zero;
		logic pin_change;
		logic usi_start;
	} scg_pin_wake_t;

endpackage : scg_pkg

// ---- hw/scg_sleep_ctrl.sv ----
// Contract
// - sleep needs enable bit plus sleep instruction
// - core halted four cycles after start-up
// - idle stops only CPU and flash clocks; here also timer 2 sync clock and unused timer oscillator
// - ADC noise mode stops IO, CPU, flash
// - ADC noise entry starts conversion if enabled
// - ADC noise mode wakes on listed events
// - power-down stops oscillator and generated clocks
// - power-down wakes only on listed events
// - power-down wake waits fuse-selected restart delay
// - power-save keeps enabled timer 2 running
// - timer 2 wake needs both enables
// - power-save stops unused timer 2 clocks
// - standby needs crystal, keeps oscillator running
// - standby wake completes in six cycles
// - gate bit stops peripheral clock, access
// - clearing gate bit resumes frozen state
// - converter stays enabled; restart gives extended conversion
// - comparator auto-off in deep sleep, unless reference
// - fused brown-out detector stays active always
// - enabled watchdog runs in all modes
// - reference enabled only when something needs it
// - input buffers off when IO, ADC stopped
// - debug fuse keeps main clock in deep sleep; here only while scan port enabled
// - disable bit or unfused port kills scan
module scg_sleep_ctrl (
	input  wire logic                  ref_clk_in,
	input  wire logic                  arst_n_in,
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic [11:0]           paddr_in,
	input  wire logic [31:0]           pwdata_in,
	output logic      [31:0]           prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out,
	input  wire logic                  sleep_instr_in,
	input  wire logic                  global_irq_en_in,
	input  wire logic [1:0]            timer2_irq_mask_in,
	input  wire logic                  t2_enable_in,
	input  wire logic                  t2_async_in,
	input  wire logic                  adc_enable_in,
	input  wire logic                  adc_uses_ref_in,
	input  wire logic                  adc_conv_begun_in,
	input  wire logic                  comp_enable_in,
	input  wire logic                  comp_uses_ref_in,
	input  wire logic                  wdt_enable_in,
	input  wire logic [3:0]            clock_source_fuses_in,
	input  wire logic [2:0]            brownout_level_fuses_in,
	input  wire logic                  debug_enable_fuse_in,
	input  wire logic                  scan_port_fuse_in,
	input  wire scg_pkg::scg_wake_t    wake_in,
	input  wire scg_pkg::scg_pin_wake_t pin_wake_in,
	output scg_pkg::scg_clk_en_t       clk_en_out,
	output logic                       t2_sync_clk_en_out,
	output logic [3:0]                 periph_clk_en_out,
	output logic                       core_halt_out,
	output logic                       adc_start_out,
	output logic                       adc_extended_out,
	output logic                       comp_off_out,
	output logic                       vref_en_out,
	output logic                       bod_en_out,
	output logic                       wdt_run_out,
	output logic                       input_buf_en_out,
	output logic                       scan_port_en_out
);

	// ************************************************************
	// Decoding
	// ************************************************************
	function automatic scg_pkg::scg_mode_t decode_mode(input logic [2:0] code, input logic xtal);
		unique case (code)
			scg_pkg::CODE_ADCNR: decode_mode = scg_pkg::MODE_ADCNR;
			scg_pkg::CODE_PDOWN: decode_mode = scg_pkg::MODE_PDOWN;
			scg_pkg::CODE_PSAVE: decode_mode = scg_pkg::MODE_PSAVE;
			// Without a crystal the oscillator may not restart fast enough
			scg_pkg::CODE_STBY:  decode_mode = xtal ? scg_pkg::MODE_STBY : scg_pkg::MODE_IDLE;
			default:             decode_mode = scg_pkg::MODE_IDLE;
		endcase
	endfunction : decode_mode

	function automatic logic reg_hit(input logic [11:0] addr);
		reg_hit = (addr == scg_pkg::SLEEP_CTRL_OFS) || (addr == scg_pkg::PERIPH_GATE_OFS) ||
			(addr == scg_pkg::MCU_CTRL_OFS) || (addr == scg_pkg::STATUS_OFS);
	endfunction : reg_hit

	// ************************************************************
	// Registers
	// ************************************************************
	logic                        se_q;
	logic [2:0]                  mode_sel_q;
	logic [scg_pkg::PRR_W-1:0]   prr_q;
	logic                        tpd_q;
	scg_pkg::scg_state_t         state_q;
	scg_pkg::scg_mode_t          mode_q;
	logic [10:0]                 cnt_q;
	logic                        adc_en_prev_q;
	logic [2:0]                  pin_meta_q;
	logic [2:0]                  pin_sync_q;

	logic                        wr_en;
	logic                        xtal;
	logic                        sleeping;
	logic                        debug_active;
	logic                        wake_ok;
	logic [10:0]                 restart_cyc;
	scg_pkg::scg_mode_t          mode_next;
	scg_pkg::scg_pin_wake_t      pin_s;
	scg_pkg::scg_clk_en_t        clk_en;

	assign wr_en        = psel_in && penable_in && pwrite_in;
	assign xtal         = clock_source_fuses_in[scg_pkg::XTAL_FUSE_BIT];
	assign mode_next    = decode_mode(mode_sel_q, xtal);
	assign sleeping     = (state_q != scg_pkg::ST_ACTIVE);
	assign pin_s        = pin_sync_q;
	assign scan_port_en_out = scan_port_fuse_in && !tpd_q;
	assign debug_active = debug_enable_fuse_in && scan_port_en_out;
	assign restart_cyc  = xtal ? scg_pkg::RESTART_XTAL_CYC : scg_pkg::RESTART_RC_CYC;

	// ************************************************************
	// APB slave, zero wait states
	// ************************************************************
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in && penable_in && !reg_hit(paddr_in);

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			se_q       <= 1'b0;
			mode_sel_q <= scg_pkg::SLEEP_CTRL_RST;
		end else if (wr_en && paddr_in == scg_pkg::SLEEP_CTRL_OFS) begin
			se_q       <= pwdata_in[scg_pkg::SE_BIT];
			mode_sel_q <= pwdata_in[scg_pkg::MODE_LSB +: scg_pkg::MODE_W];
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prr_q <= scg_pkg::PRR_RST;
		end else if (wr_en && paddr_in == scg_pkg::PERIPH_GATE_OFS) begin
			prr_q <= pwdata_in[scg_pkg::PRR_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tpd_q <= 1'b0;
		end else if (wr_en && paddr_in == scg_pkg::MCU_CTRL_OFS) begin
			tpd_q <= pwdata_in[scg_pkg::TPD_BIT];
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			prdata_out <= 32'h0000_0000;
			unique case (paddr_in)
				scg_pkg::SLEEP_CTRL_OFS:  prdata_out[3:0] <= {mode_sel_q, se_q};
				scg_pkg::PERIPH_GATE_OFS: prdata_out[scg_pkg::PRR_W-1:0] <= prr_q;
				scg_pkg::MCU_CTRL_OFS:    prdata_out[scg_pkg::TPD_BIT] <= tpd_q;
				scg_pkg::STATUS_OFS: begin
					prdata_out[scg_pkg::ST_STATE_LSB +: 4] <= state_q;
					prdata_out[scg_pkg::ST_CLK_LSB +: 7]   <= clk_en;
				end
				default:                  prdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// Pin wake synchroniser
	// ************************************************************
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
		end else begin
			pin_meta_q <= pin_wake_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ************************************************************
	// Wake qualification
	// ************************************************************
	// A level on the external pin must outlast the synchroniser to be seen
	always_comb begin
		logic rst_wake;
		logic pin_wake;
		logic t2_wake;
		rst_wake = wake_in.ext_reset || wake_in.wdt_reset || wake_in.bod_reset;
		pin_wake = pin_s.ext_irq_zero || pin_s.pin_change || pin_s.usi_start;
		t2_wake  = global_irq_en_in && ((wake_in.t2_ovf && timer2_irq_mask_in[0]) ||
			(wake_in.t2_cmp && timer2_irq_mask_in[1]));
		unique case (mode_q)
			scg_pkg::MODE_ADCNR: wake_ok = rst_wake || pin_wake || wake_in.adc_done ||
				wake_in.spm_ready || t2_wake;
			scg_pkg::MODE_PSAVE: wake_ok = rst_wake || pin_wake || t2_wake;
			scg_pkg::MODE_PDOWN,
			scg_pkg::MODE_STBY:  wake_ok = rst_wake || pin_wake;
			default:             wake_ok = rst_wake || pin_wake || wake_in.adc_done || wake_in.spm_ready ||
				wake_in.other_io || t2_wake;
		endcase
	end

	// ************************************************************
	// Sleep sequencer
	// ************************************************************
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= scg_pkg::ST_ACTIVE;
			mode_q  <= scg_pkg::MODE_IDLE;
			cnt_q   <= 11'h000;
		end else begin
			unique case (state_q)
				scg_pkg::ST_ACTIVE: begin
					if (sleep_instr_in && se_q) begin
						state_q <= scg_pkg::ST_SLEEP;
						mode_q  <= mode_next;
					end
				end
				scg_pkg::ST_SLEEP: begin
					if (wake_ok) begin
						unique case (mode_q)
							scg_pkg::MODE_PDOWN, scg_pkg::MODE_PSAVE: begin
								state_q <= scg_pkg::ST_RESTART;
								cnt_q   <= restart_cyc - 11'h001;
							end
							scg_pkg::MODE_STBY: begin
								state_q <= scg_pkg::ST_RESTART;
								cnt_q   <= scg_pkg::STBY_WAKE_CYC - 11'h001;
							end
							default: begin
								state_q <= scg_pkg::ST_HALT;
								cnt_q   <= scg_pkg::HALT_CYC - 11'h001;
							end
						endcase
					end
				end
				scg_pkg::ST_RESTART: begin
					if (cnt_q == 11'h000) begin
						state_q <= scg_pkg::ST_HALT;
						cnt_q   <= scg_pkg::HALT_CYC - 11'h001;
					end else begin
						cnt_q <= cnt_q - 11'h001;
					end
				end
				scg_pkg::ST_HALT: begin
					if (cnt_q == 11'h000) begin
						state_q <= scg_pkg::ST_ACTIVE;
					end else begin
						cnt_q <= cnt_q - 11'h001;
					end
				end
				default: begin
					state_q <= scg_pkg::ST_ACTIVE;
				end
			endcase
		end
	end

	assign core_halt_out = sleeping;

	// ************************************************************
	// Clock domain gating
	// ************************************************************
	always_comb begin
		clk_en = '1;
		t2_sync_clk_en_out = !sleeping;
		if (state_q == scg_pkg::ST_SLEEP || state_q == scg_pkg::ST_RESTART) begin
			clk_en.cpu   = 1'b0;
			clk_en.flash = 1'b0;
			clk_en.timer_osc = t2_enable_in && t2_async_in;
			unique case (mode_q)
				scg_pkg::MODE_IDLE: ;
				scg_pkg::MODE_ADCNR: begin
					clk_en.io = 1'b0;
				end
				scg_pkg::MODE_PSAVE: begin
					clk_en.io  = 1'b0;
					clk_en.adc = 1'b0;
					clk_en.asy = t2_enable_in;
					// Synchronous clock kept alive only for timer 2
					t2_sync_clk_en_out = t2_enable_in && !t2_async_in;
					clk_en.main_osc = t2_sync_clk_en_out || debug_active;
				end
				scg_pkg::MODE_STBY: begin
					clk_en.io  = 1'b0;
					clk_en.adc = 1'b0;
					clk_en.asy = 1'b0;
					clk_en.timer_osc = 1'b0;
				end
				default: begin
					clk_en.io  = 1'b0;
					clk_en.adc = 1'b0;
					clk_en.asy = 1'b0;
					clk_en.timer_osc = 1'b0;
					clk_en.main_osc  = debug_active;
				end
			endcase
			// The restart delay is counted on the returning main clock
			if (state_q == scg_pkg::ST_RESTART) begin
				clk_en.main_osc = 1'b1;
			end
		end else if (state_q == scg_pkg::ST_HALT) begin
			clk_en.cpu   = 1'b0;
			clk_en.flash = 1'b0;
		end
	end

	assign clk_en_out = clk_en;

	// ************************************************************
	// Peripheral gating
	// ************************************************************
	// Gating only stops the clock; state is kept so ungating resumes it
	genvar g;
	generate
		for (g = 0; g < scg_pkg::PRR_W; g++) begin : g_periph
			assign periph_clk_en_out[g] = !prr_q[g] && clk_en.io;
		end
	endgenerate

	// ************************************************************
	// Analog and supervisory enables
	// ************************************************************
	logic deep_sleep;
	assign deep_sleep = sleeping && !(mode_q == scg_pkg::MODE_IDLE || mode_q == scg_pkg::MODE_ADCNR);

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			adc_start_out <= 1'b0;
		end else begin
			adc_start_out <= (state_q == scg_pkg::ST_ACTIVE) && sleep_instr_in && se_q && adc_enable_in &&
				(mode_next == scg_pkg::MODE_ADCNR || mode_next == scg_pkg::MODE_IDLE);
		end
	end

	// Re-enabling the converter marks the next conversion as extended
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			adc_en_prev_q    <= 1'b0;
			adc_extended_out <= 1'b1;
		end else begin
			adc_en_prev_q <= adc_enable_in;
			if (adc_enable_in && !adc_en_prev_q) begin
				adc_extended_out <= 1'b1;
			end else if (adc_conv_begun_in) begin
				adc_extended_out <= 1'b0;
			end
		end
	end

	assign comp_off_out = deep_sleep && !comp_uses_ref_in;
	assign bod_en_out   = brownout_level_fuses_in != scg_pkg::BOD_OFF_CODE;
	assign wdt_run_out  = wdt_enable_in;
	assign vref_en_out  = bod_en_out || (comp_enable_in && !comp_off_out && comp_uses_ref_in) ||
		(adc_enable_in && adc_uses_ref_in);
	// Wake pins have their own always-on buffers
	assign input_buf_en_out = !(sleeping && !clk_en.io && !clk_en.adc);

	// ************************************************************
	// Checks
	// ************************************************************
	AST_NO_SLEEP_WITHOUT_SE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_q == scg_pkg::ST_ACTIVE && !se_q) |=> state_q == scg_pkg::ST_ACTIVE)
		else $error("sleep entered without enable bit");

	AST_HALT_FOUR: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_q == scg_pkg::ST_HALT && $past(state_q) != scg_pkg::ST_HALT) |->
		(state_q == scg_pkg::ST_HALT)[*4] ##1 state_q == scg_pkg::ST_ACTIVE)
		else $error("halt after wake is not four cycles");

	AST_IDLE_CLOCKS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_q == scg_pkg::ST_SLEEP && mode_q == scg_pkg::MODE_IDLE) |->
		(!clk_en_out.cpu && !clk_en_out.flash && clk_en_out.io && clk_en_out.adc && clk_en_out.main_osc))
		else $error("idle clock set wrong");

	AST_ADCNR_CLOCKS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_q == scg_pkg::ST_SLEEP && mode_q == scg_pkg::MODE_ADCNR) |->
		(!clk_en_out.io && !clk_en_out.cpu && clk_en_out.adc && clk_en_out.asy))
		else $error("noise reduction clock set wrong");

	AST_ADC_START: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_q == scg_pkg::ST_ACTIVE && sleep_instr_in && se_q && adc_enable_in &&
		mode_next == scg_pkg::MODE_ADCNR) |=> adc_start_out && state_q == scg_pkg::ST_SLEEP)
		else $error("no conversion start on noise reduction entry");

	AST_PDOWN_STAYS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_q == scg_pkg::ST_SLEEP && mode_q == scg_pkg::MODE_PDOWN && pin_sync_q == 3'h0 &&
		!wake_in.ext_reset && !wake_in.wdt_reset && !wake_in.bod_reset) |=> state_q == scg_pkg::ST_SLEEP)
		else $error("power-down left on an illegal source");

	AST_STBY_SIX: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_q == scg_pkg::ST_SLEEP && mode_q == scg_pkg::MODE_STBY && wake_ok) |=>
		(state_q == scg_pkg::ST_RESTART)[*6] ##1 state_q == scg_pkg::ST_HALT)
		else $error("standby wake not six cycles");

	AST_PRR_GATES: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		$rose(prr_q[0]) |-> !periph_clk_en_out[0] && $past(periph_clk_en_out[0]) == $past(clk_en.io))
		else $error("gate bit did not stop peripheral clock");

	AST_SCAN_DISABLE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(tpd_q || !scan_port_fuse_in) |-> !scan_port_en_out)
		else $error("scan port left enabled");

endmodule : scg_sleep_ctrl

// ---- verification/scg_core_model.sv ----
module scg_core_model (
	input  wire logic ref_clk_in,
	input  wire logic arst_n_in,
	input  wire logic sleep_req_in,
	input  wire logic pin_req_in,
	input  wire logic core_halt_in,
	input  wire logic adc_start_in,
	output logic      sleep_instr_out,
	output logic      pin_change_out,
	output logic      adc_conv_begun_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Core side and wake pin source
	// ************************************************************
	logic [2:0] hold_q;

	// A halted core cannot execute another sleep instruction
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sleep_instr_out <= 1'b0;
		end else begin
			sleep_instr_out <= sleep_req_in & ~core_halt_in;
		end
	end

	// Level held past the two-flop synchroniser, else the wake could be lost
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hold_q <= 3'h0;
		end else if (pin_req_in) begin
			hold_q <= 3'h4;
		end else if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
		end
	end
	assign pin_change_out = (hold_q != 3'h0);

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			adc_conv_begun_out <= 1'b0;
		end else begin
			adc_conv_begun_out <= adc_start_in;
		end
	end
endmodule : scg_core_model

// ---- verification/sleep_mode_clock_gating_test.sv ----
module sleep_mode_clock_gating_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic sleep_req, pin_req, sleep_instr, pin_chg, conv_begun, gie, adc_en, adc_ref, comp_en, comp_ref;
	logic wdt_en, dbg, scan, tpd, xt, t2_sync, halt, adc_start, adc_ext, comp_off, vref, bod_on, wdt_run;
	logic ibuf, scan_en;
	logic [1:0] t2_mask;
	logic [2:0] bod, cd, ce;
	logic [3:0] cks, g, periph;
	logic [6:0] ex;
	scg_pkg::scg_wake_t wake;
	scg_pkg::scg_clk_en_t clk_en;
	int err_total, n_tests, n;

	scg_sleep_ctrl u_scg_sleep_ctrl (.ref_clk_in(ref_clk), .arst_n_in(arst_n), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .sleep_instr_in(sleep_instr), .global_irq_en_in(gie),
		.timer2_irq_mask_in(t2_mask), .t2_enable_in(1'b1), .t2_async_in(1'b1), .adc_enable_in(adc_en),
		.adc_uses_ref_in(adc_ref), .adc_conv_begun_in(conv_begun), .comp_enable_in(comp_en),
		.comp_uses_ref_in(comp_ref), .wdt_enable_in(wdt_en), .clock_source_fuses_in(cks),
		.brownout_level_fuses_in(bod), .debug_enable_fuse_in(dbg), .scan_port_fuse_in(scan), .wake_in(wake),
		.pin_wake_in({1'b0, pin_chg, 1'b0}), .clk_en_out(clk_en), .t2_sync_clk_en_out(t2_sync),
		.periph_clk_en_out(periph), .core_halt_out(halt), .adc_start_out(adc_start),
		.adc_extended_out(adc_ext), .comp_off_out(comp_off), .vref_en_out(vref), .bod_en_out(bod_on),
		.wdt_run_out(wdt_run), .input_buf_en_out(ibuf), .scan_port_en_out(scan_en));

	scg_core_model u_scg_core_model (.ref_clk_in(ref_clk), .arst_n_in(arst_n), .sleep_req_in(sleep_req),
		.pin_req_in(pin_req), .core_halt_in(halt), .adc_start_in(adc_start), .sleep_instr_out(sleep_instr),
		.pin_change_out(pin_chg), .adc_conv_begun_out(conv_begun));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic end_of_test();
		if (err_total == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (!ok) begin
			err_total++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic pulse(input logic [7:0] w);
		wake <= w;
		@(posedge ref_clk);
		wake <= 8'h00;
	endtask : pulse

	function automatic logic [6:0] exp_clk(input logic [2:0] e, input logic d);
		case (e)
			scg_pkg::CODE_ADCNR: exp_clk = 7'h0F;
			scg_pkg::CODE_PDOWN: exp_clk = {5'h00, d, 1'b0};
			scg_pkg::CODE_PSAVE: exp_clk = {4'h0, 1'b1, d, 1'b1};
			scg_pkg::CODE_STBY:  exp_clk = 7'h02;
			default:             exp_clk = 7'h1F;
		endcase
	endfunction : exp_clk

	function automatic int halt_len(input logic [2:0] e, input logic x);
		if (e == scg_pkg::CODE_STBY) return int'(scg_pkg::STBY_WAKE_CYC) + int'(scg_pkg::HALT_CYC);
		if (e == scg_pkg::CODE_PDOWN || e == scg_pkg::CODE_PSAVE)
			return int'(x ? scg_pkg::RESTART_XTAL_CYC : scg_pkg::RESTART_RC_CYC) + int'(scg_pkg::HALT_CYC);
		return int'(scg_pkg::HALT_CYC);
	endfunction : halt_len

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		#200_000;
		err_total++;
		end_of_test();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{arst_n, psel, penable, pwrite, sleep_req, pin_req, gie, adc_en, adc_ref, comp_en, comp_ref} = 11'h000;
		{wdt_en, dbg, scan, paddr, pwdata, t2_mask, cks, bod, wake} = '0;
		void'($urandom(76));
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0000_0000);
			chk(rd === ((i == 3) ? 32'h0000_07F1 : 32'h0000_0000) && err === (i == 4), "reset read");
		end
		chk(adc_ext === 1'b1, "extended after reset");
		adc_en <= 1'b1;
		apb(1'b1, scg_pkg::SLEEP_CTRL_OFS, 32'h0000_0004);
		sleep_req <= 1'b1;
		@(posedge ref_clk) sleep_req <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 chk(halt === 1'b0 && adc_start === 1'b0, "slept without enable");
		adc_en <= 1'b0;
		repeat (2) @(posedge ref_clk);
		adc_en <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 chk(adc_ext === 1'b1, "no extended conversion");
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 8; c++) begin
				cd = 3'(c);
				xt = (p == 0);
				ce = (c < 4 || (cd == scg_pkg::CODE_STBY && xt)) ? cd : scg_pkg::CODE_IDLE;
				g = 4'($urandom);
				tpd = 1'($urandom);
				{adc_en, adc_ref, comp_en, comp_ref, wdt_en, dbg, scan} <= 7'($urandom);
				{cks, bod, gie, t2_mask} <= {xt, 3'($urandom), 3'($urandom), 1'b1, 2'h1};
				apb(1'b1, scg_pkg::PERIPH_GATE_OFS, {28'h000_0000, g});
				apb(1'b1, scg_pkg::MCU_CTRL_OFS, {31'h0000_0000, tpd});
				apb(1'b1, scg_pkg::SLEEP_CTRL_OFS, {28'($urandom), cd, 1'b1});
				apb(1'b0, scg_pkg::SLEEP_CTRL_OFS, 32'h0000_0000);
				#1 chk(rd === {28'h000_0000, cd, 1'b1}, "control readback");
				chk(bod_on === (bod != scg_pkg::BOD_OFF_CODE) && wdt_run === wdt_en, "bod or wdt");
				chk(vref === (bod_on | (comp_en & comp_ref) | (adc_en & adc_ref)), "vref");
				chk(scan_en === (scan & ~tpd) && periph === ~g, "scan or gate");
				sleep_req <= 1'b1;
				@(posedge ref_clk) sleep_req <= 1'b0;
				@(posedge ref_clk);
				// Debug keeps the main clock only while the scan port is alive
				ex = exp_clk(ce, dbg & scan & ~tpd);
				#1 chk(halt === 1'b1 && clk_en === ex, "sleep clocks");
				chk(adc_start === (adc_en & (ce < 2)), "conversion start");
				chk(ibuf === (ex[4] | ex[3]) && periph === (~g & {4{ex[4]}}), "buffers or gate");
				if (!comp_ref) chk(comp_off === (ce > 1), "comparator");
				apb(1'b0, scg_pkg::STATUS_OFS, 32'h0000_0000);
				chk(rd === {21'h00_0000, ex, 4'h2}, "status in sleep");
				if (ce != scg_pkg::CODE_IDLE) begin
					pulse(8'h01);
					if (ce == scg_pkg::CODE_PSAVE) gie <= 1'b0;
					repeat (3) @(posedge ref_clk);
					if (ce == scg_pkg::CODE_PSAVE) pulse(8'h08);
					repeat (3) @(posedge ref_clk);
					#1 chk(halt === 1'b1, "woke on barred source");
					gie <= 1'b1;
				end
				n = 0;
				if (ce == scg_pkg::CODE_PDOWN) begin
					pin_req <= 1'b1;
					@(posedge ref_clk) pin_req <= 1'b0;
				end else begin
					pulse((ce == 0) ? 8'h01 : (ce == 1) ? 8'h80 : (ce == 3) ? 8'h08 : 8'h40);
				end
				while (halt !== 1'b0 && n < 1200) begin
					@(posedge ref_clk);
					#1 n++;
				end
				if (ce == scg_pkg::CODE_PDOWN) chk(halt === 1'b0, "pin wake");
				else chk(n == halt_len(ce, xt), "wake length");
				chk(clk_en === 7'h7F, "clocks after wake");
			end
		end
		end_of_test();
	end
endmodule : sleep_mode_clock_gating_test
